// File: rtl/bridge_parity_pkg.sv
// Shared constants, register map and carrier types of the parity handler.
// Assumes one clock, a synchronous active-low reset and an AXI4-Lite master.
package bridge_parity_pkg;

  // ***************************************************************
  // Sides and timing
  // ***************************************************************
  localparam int SIDES      = 2;
  localparam int SIDE_PRI   = 0;
  localparam int SIDE_SEC   = 1;
  localparam int PERR_DELAY = 2;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam int         AXI_ADDR_W = 8;
  localparam logic [7:0] CMD_OFF    = 8'h00;
  localparam logic [7:0] BCTL_OFF   = 8'h04;
  localparam logic [7:0] STAT_OFF   = 8'h08;
  localparam logic [7:0] MASK_OFF   = 8'h0c;
  localparam logic [7:0] QSTAT_OFF  = 8'h10;

  localparam int         RESP_BIT   = 0;
  localparam int         STAT_DET   = 0;
  localparam int         STAT_DPD   = 1;
  localparam int         STAT_W     = 4;

  localparam logic [7:0]        CMD_RST  = 8'h00;
  localparam logic [7:0]        BCTL_RST = 8'h00;
  localparam logic [STAT_W-1:0] STAT_RST = 4'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 4'h0;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ***************************************************************
  // Carrier types
  // ***************************************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [31:0] data;
    logic [3:0]  be;
    logic        par_err;
    logic        multi;
  } dw_req_s;

  typedef struct packed {
    logic    cfg_wr;
    logic    cfg_pe;
    logic    rd_vld;
    logic    rd_pe;
    logic    rd_ret;
    logic    rd_flush;
    logic    dw_phase;
    dw_req_s dw;
    logic    dw_dlv;
    logic    dw_done;
  } side_in_s;

  typedef struct packed {
    logic    trdy;
    logic    stop;
    logic    retry;
    logic    cfg_store;
    logic    perr_l;
    logic    perr_oe;
    logic    fwd_par;
    logic    fwd_par_vld;
    logic    q_valid;
    dw_req_s q;
  } side_out_s;

endpackage : bridge_parity_pkg

// File: rtl/bridge_data_parity_handler.sv
// Data parity error handling for both faces of a PCI-to-PCI bridge.
// Assumes the bridge core drives side_in on aclk; only the parity error
// pins arrive from outside and are synchronised here.
//
// Function
// - Forward the received parity condition across the bridge unchanged.
// - Config write parity error, response on: ready, store, parity error.
// - Response off: no parity error; detected bit set either way.
// - Downstream read error: secondary parity error two cycles later.
// - Secondary detected always; data parity detected if response on.
// - Upstream read error: primary parity error two cycles later.
// - Primary data parity detected only when response on.
// - Return read parity as received; drop unread prefetched data.
// - Parity error from initiator during read return is ignored.
// - Normal delayed write is captured whole and answered with retry.
// - Initial delayed write error, response on: ready, stop if multiple phases, parity error.
// - Response off: retry and queue; detected bit always set.
// - Target parity error on delivery: data parity bit if response on, capture.
// - Repeat matches on address, command, data, byte enables, not parity.
// - Repeat with error and status: ready, parity error, stay queued.
// - Error from target only: report if both responses on, complete.
// - Unchecked parity may leave repeats unmatched until master timeout.
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/100ps

module bridge_data_parity_handler
  import bridge_parity_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite register port
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Bridge core, index 0 primary and 1 secondary
  input  wire side_in_s [SIDES-1:0]  side_in,
  input  wire logic [SIDES-1:0]      perr_in_l,
  output side_out_s [SIDES-1:0]      side_out,
  // Interrupt
  output logic                       irq
);

  // ***************************************************************
  // Parity error pin synchronisers
  // ***************************************************************
  logic [SIDES-1:0] perr_meta_ff;
  logic [SIDES-1:0] perr_sync_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      perr_meta_ff <= '1;
      perr_sync_ff <= '1;
    end else begin
      perr_meta_ff <= perr_in_l;
      perr_sync_ff <= perr_meta_ff;
    end
  end

  // ***************************************************************
  // Shared state between the two sides and the register file
  // ***************************************************************
  logic [SIDES-1:0] resp;
  logic [SIDES-1:0] det_set;
  logic [SIDES-1:0] dpd_set;
  logic [SIDES-1:0] qv_vec;
  logic [SIDES-1:0] qdone_vec;

  // ***************************************************************
  // Per-side parity handling
  // ***************************************************************
  for (genvar k = 0; k < SIDES; k++) begin : g_side
    localparam int O = SIDES - 1 - k;

    side_out_s out_ff;
    side_out_s nxt_out;
    logic      pe1_ff;
    logic      nxt_pe1;
    dw_req_s   q_ff;
    dw_req_s   nxt_q;
    logic      qv_ff;
    logic      nxt_qv;
    logic      qdone_ff;
    logic      nxt_qdone;
    logic      qtpe_ff;
    logic      nxt_qtpe;
    logic      hold_ff;
    logic      nxt_hold;
    logic      holdv_ff;
    logic      nxt_holdv;
    logic      pe_req;
    logic      match;

    always_comb begin
      nxt_out             = out_ff;
      nxt_out.trdy        = 1'b0;
      nxt_out.stop        = 1'b0;
      nxt_out.retry       = 1'b0;
      nxt_out.cfg_store   = 1'b0;
      nxt_out.fwd_par_vld = 1'b0;
      nxt_q               = q_ff;
      nxt_qv              = qv_ff;
      nxt_qdone           = qdone_ff;
      nxt_qtpe            = qtpe_ff;
      nxt_hold            = hold_ff;
      nxt_holdv           = holdv_ff;
      pe_req              = 1'b0;
      det_set[k]          = 1'b0;
      dpd_set[k]          = 1'b0;
      // Parity takes no part in the match, so a repeat with a parity
      // slip still finds its entry; with checking off a corrupted
      // repeat can miss and leave the entry to time out.
      match = qv_ff &&
              side_in[k].dw.addr == q_ff.addr &&
              side_in[k].dw.cmd  == q_ff.cmd  &&
              side_in[k].dw.data == q_ff.data &&
              side_in[k].dw.be   == q_ff.be;

      // Bridge as initiator: read data from a target on this side.
      if (side_in[k].rd_vld && side_in[k].rd_pe) begin
        det_set[k] = 1'b1;
        if (resp[k]) begin
          pe_req     = 1'b1;
          dpd_set[k] = 1'b1;
        end
      end

      // Bridge as target returning read data fetched on the far side.
      // An initiator parity error seen meanwhile is left to the
      // initiator, so nothing here looks at the pin.
      if (side_in[k].rd_ret && holdv_ff) begin
        nxt_out.fwd_par_vld = 1'b1;
        nxt_out.fwd_par     = hold_ff;
        nxt_holdv           = 1'b0;
      end
      if (side_in[k].rd_flush) begin
        nxt_holdv = 1'b0;
      end
      if (side_in[O].rd_vld) begin
        nxt_holdv = 1'b1;
        nxt_hold  = side_in[O].rd_pe;
      end

      // Type 0 write to own configuration space, primary face only.
      if (k == SIDE_PRI && side_in[k].cfg_wr) begin
        nxt_out.trdy      = 1'b1;
        nxt_out.cfg_store = 1'b1;
        if (side_in[k].cfg_pe) begin
          det_set[k] = 1'b1;
          pe_req     = resp[k];
        end
      end

      // Delayed write data phase from an initiator on this side.
      if (side_in[k].dw_phase) begin
        det_set[k] = side_in[k].dw.par_err;
        if (!qv_ff) begin
          if (side_in[k].dw.par_err && resp[k]) begin
            nxt_out.trdy = 1'b1;
            nxt_out.stop = side_in[k].dw.multi;
            pe_req       = 1'b1;
          end else begin
            nxt_out.retry = 1'b1;
            nxt_q         = side_in[k].dw;
            nxt_qv        = 1'b1;
            nxt_qdone     = 1'b0;
            nxt_qtpe      = 1'b0;
          end
        end else if (match && qdone_ff) begin
          nxt_out.trdy = 1'b1;
          if (side_in[k].dw.par_err) begin
            pe_req = resp[k];
          end else begin
            nxt_qv = 1'b0;
            if (qtpe_ff && !q_ff.par_err && (&resp)) begin
              pe_req = 1'b1;
            end
          end
        end else begin
          nxt_out.retry = 1'b1;
        end
      end

      // Delivery of this side's queued write on the far side.
      if (side_in[O].dw_dlv && !perr_sync_ff[O]) begin
        nxt_qtpe = 1'b1;
      end
      if (side_in[O].dw_done) begin
        nxt_qdone = 1'b1;
      end

      // Target on this side flags parity while the bridge delivers.
      if (side_in[k].dw_dlv && !perr_sync_ff[k] && resp[k]) begin
        dpd_set[k] = 1'b1;
      end

      // Two stages put the pin two cycles after the data transfer.
      nxt_pe1         = pe_req;
      nxt_out.perr_l  = !pe1_ff;
      nxt_out.perr_oe = pe1_ff;
      nxt_out.q_valid = nxt_qv;
      nxt_out.q       = nxt_q;
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_ff        <= '0;
        out_ff.perr_l <= 1'b1;
        pe1_ff        <= 1'b0;
        q_ff          <= '0;
        qv_ff         <= 1'b0;
        qdone_ff      <= 1'b0;
        qtpe_ff       <= 1'b0;
        hold_ff       <= 1'b0;
        holdv_ff      <= 1'b0;
      end else begin
        out_ff        <= nxt_out;
        pe1_ff        <= nxt_pe1;
        q_ff          <= nxt_q;
        qv_ff         <= nxt_qv;
        qdone_ff      <= nxt_qdone;
        qtpe_ff       <= nxt_qtpe;
        hold_ff       <= nxt_hold;
        holdv_ff      <= nxt_holdv;
      end
    end

    assign side_out[k]  = out_ff;
    assign qv_vec[k]    = qv_ff;
    assign qdone_vec[k] = qdone_ff;
  end

  // ***************************************************************
  // Register file and AXI4-Lite slave
  // ***************************************************************
  logic [7:0]            cmd_ff;
  logic [7:0]            nxt_cmd;
  logic [7:0]            bctl_ff;
  logic [7:0]            nxt_bctl;
  logic [STAT_W-1:0]     stat_ff;
  logic [STAT_W-1:0]     nxt_stat;
  logic [STAT_W-1:0]     mask_ff;
  logic [STAT_W-1:0]     nxt_mask;
  logic [STAT_W-1:0]     stat_set;
  logic [STAT_W-1:0]     stat_clr;
  logic [AXI_ADDR_W-1:0] awaddr_ff;
  logic [AXI_ADDR_W-1:0] nxt_awaddr;
  logic                  awv_ff;
  logic                  nxt_awv;
  logic [31:0]           wdata_ff;
  logic [31:0]           nxt_wdata;
  logic                  wlo_ff;
  logic                  nxt_wlo;
  logic                  wv_ff;
  logic                  nxt_wv;
  logic                  awready_ff;
  logic                  nxt_awready;
  logic                  wready_ff;
  logic                  nxt_wready;
  logic                  bvalid_ff;
  logic                  nxt_bvalid;
  logic [1:0]            bresp_ff;
  logic [1:0]            nxt_bresp;
  logic                  arready_ff;
  logic                  nxt_arready;
  logic                  rvalid_ff;
  logic                  nxt_rvalid;
  logic [31:0]           rdata_ff;
  logic [31:0]           nxt_rdata;
  logic [1:0]            rresp_ff;
  logic [1:0]            nxt_rresp;
  logic                  irq_ff;
  logic                  nxt_irq;

  assign resp = {bctl_ff[RESP_BIT], cmd_ff[RESP_BIT]};

  always_comb begin
    nxt_cmd     = cmd_ff;
    nxt_bctl    = bctl_ff;
    nxt_mask    = mask_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_awv     = awv_ff;
    nxt_wdata   = wdata_ff;
    nxt_wlo     = wlo_ff;
    nxt_wv      = wv_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    stat_clr    = '0;
    for (int s = 0; s < SIDES; s++) begin
      stat_set[2*s+STAT_DET] = det_set[s];
      stat_set[2*s+STAT_DPD] = dpd_set[s];
    end

    if (s_axi_awvalid && awready_ff) begin
      nxt_awaddr = s_axi_awaddr;
      nxt_awv    = 1'b1;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_wdata = s_axi_wdata;
      nxt_wlo   = s_axi_wstrb[0];
      nxt_wv    = 1'b1;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end

    // Address and data may arrive in either order; the write acts once
    // both are held and no earlier response is still outstanding.
    if (awv_ff && wv_ff && !bvalid_ff) begin
      nxt_awv    = 1'b0;
      nxt_wv     = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = AXI_OKAY;
      case (awaddr_ff)
        CMD_OFF: begin
          if (wlo_ff) nxt_cmd = wdata_ff[7:0];
        end
        BCTL_OFF: begin
          if (wlo_ff) nxt_bctl = wdata_ff[7:0];
        end
        STAT_OFF: begin
          if (wlo_ff) stat_clr = wdata_ff[STAT_W-1:0];
        end
        MASK_OFF: begin
          if (wlo_ff) nxt_mask = wdata_ff[STAT_W-1:0];
        end
        QSTAT_OFF: begin
          nxt_bresp = AXI_OKAY;
        end
        default: begin
          nxt_bresp = AXI_SLVERR;
        end
      endcase
    end

    // A fresh event outranks a clear of the same bit.
    nxt_stat = (stat_ff & ~stat_clr) | stat_set;

    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = AXI_OKAY;
      nxt_rdata  = '0;
      case (s_axi_araddr)
        CMD_OFF:   nxt_rdata[7:0]        = cmd_ff;
        BCTL_OFF:  nxt_rdata[7:0]        = bctl_ff;
        STAT_OFF:  nxt_rdata[STAT_W-1:0] = stat_ff;
        MASK_OFF:  nxt_rdata[STAT_W-1:0] = mask_ff;
        QSTAT_OFF: nxt_rdata[3:0]        = {qdone_vec, qv_vec};
        default:   nxt_rresp             = AXI_SLVERR;
      endcase
    end

    nxt_awready = !nxt_awv;
    nxt_wready  = !nxt_wv;
    nxt_arready = !nxt_rvalid;
    nxt_irq     = |(nxt_stat & nxt_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_ff     <= CMD_RST;
      bctl_ff    <= BCTL_RST;
      stat_ff    <= STAT_RST;
      mask_ff    <= MASK_RST;
      awaddr_ff  <= '0;
      awv_ff     <= 1'b0;
      wdata_ff   <= '0;
      wlo_ff     <= 1'b0;
      wv_ff      <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= AXI_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= AXI_OKAY;
      irq_ff     <= 1'b0;
    end else begin
      cmd_ff     <= nxt_cmd;
      bctl_ff    <= nxt_bctl;
      stat_ff    <= nxt_stat;
      mask_ff    <= nxt_mask;
      awaddr_ff  <= nxt_awaddr;
      awv_ff     <= nxt_awv;
      wdata_ff   <= nxt_wdata;
      wlo_ff     <= nxt_wlo;
      wv_ff      <= nxt_wv;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      irq_ff     <= nxt_irq;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign irq           = irq_ff;

endmodule : bridge_data_parity_handler

// File: tb/bridge_parity_props.sv
// Concurrent checks on the core-side ports of the parity handler.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/100ps

module bridge_parity_props
  import bridge_parity_pkg::*;
(
  // Clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Core side
  input wire side_in_s [SIDES-1:0] side_in,
  input wire logic [SIDES-1:0]     perr_in_l,
  input wire side_out_s [SIDES-1:0] side_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  for (genvar k = 0; k < SIDES; k++) begin : g_side
    property p_perr_pair;
      side_out[k].perr_oe == !side_out[k].perr_l;
    endproperty
    a_perr_pair: assert property (p_perr_pair)
      else $error("parity error drive and enable disagree");
    property p_perr_cause;
      side_out[k].perr_oe |-> $past(side_in[k].dw_phase |
        (side_in[k].rd_vld & side_in[k].rd_pe) |
        (side_in[k].cfg_wr & side_in[k].cfg_pe), 2);
    endproperty
    a_perr_cause: assert property (p_perr_cause)
      else $error("parity error without a cause two cycles before");
    property p_cfg_done;
      side_in[k].cfg_wr |=> side_out[k].trdy && side_out[k].cfg_store;
    endproperty
    a_cfg_done: assert property (p_cfg_done)
      else $error("config write not completed and stored");
    property p_dw_answer;
      side_in[k].dw_phase |=> side_out[k].trdy != side_out[k].retry;
    endproperty
    a_dw_answer: assert property (p_dw_answer)
      else $error("write phase without exactly one answer");
    property p_stop_multi;
      side_out[k].stop |-> side_out[k].trdy && $past(side_in[k].dw.multi);
    endproperty
    a_stop_multi: assert property (p_stop_multi)
      else $error("disconnect without ready or multiple phases");
    property p_retry_queued;
      side_out[k].retry |-> side_out[k].q_valid;
    endproperty
    a_retry_queued: assert property (p_retry_queued)
      else $error("retry given with nothing queued");
    property p_capture;
      side_out[k].retry && !$past(side_out[k].q_valid)
        |-> side_out[k].q == $past(side_in[k].dw);
    endproperty
    a_capture: assert property (p_capture)
      else $error("queued write differs from the request");
    property p_fwd;
      side_out[k].fwd_par_vld |-> $past(side_in[k].rd_ret);
    endproperty
    a_fwd: assert property (p_fwd)
      else $error("parity forwarded without a read return");
  end

  c_stop: cover property (side_out[0].stop);
  c_fwd_bad: cover property (side_out[0].fwd_par_vld && side_out[0].fwd_par);
  c_perr_sec: cover property (side_out[1].perr_oe);
endmodule : bridge_parity_props

bind bridge_data_parity_handler bridge_parity_props i_bridge_parity_props (
  .aclk(aclk), .aresetn(aresetn), .side_in(side_in),
  .perr_in_l(perr_in_l), .side_out(side_out));

// File: tb/pci_far_end.sv
// Far-side PCI agents: report parity errors on the error pins.
// Assumes the bench pulses report in the cycle of the data transfer.
`timescale 1ns/100ps

module pci_far_end
  import bridge_parity_pkg::*;
(
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // One request per side, in the transfer cycle
  input wire logic [SIDES-1:0] report,
  // Error pins, pulled up while idle
  output logic [SIDES-1:0]     perr_in_l
);
  logic [SIDES-1:0] d1_ff;
  logic [SIDES-1:0] d2_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      d1_ff <= '0;
      d2_ff <= '0;
    end else begin
      d1_ff <= report;
      d2_ff <= d1_ff;
    end
  end

  // Driven low for one cycle two cycles after the transfer.
  assign perr_in_l = ~d2_ff;
endmodule : pci_far_end

// File: tb/bridge_data_parity_handler_tb_top.sv
// Self-checking bench for the parity handler.
// Assumes the design answers within a few cycles on every port.
`timescale 1ns/100ps

module bridge_data_parity_handler_tb_top
  import bridge_parity_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [AXI_ADDR_W-1:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]            s_axi_wdata, s_axi_rdata;
  logic [3:0]             s_axi_wstrb;
  logic [1:0]             s_axi_bresp, s_axi_rresp;
  side_in_s [SIDES-1:0]   side_in;
  side_out_s [SIDES-1:0]  side_out, o1, o2;
  logic [SIDES-1:0]       perr_in_l, report;
  int                     fails, total_checks, cyc;

  bridge_data_parity_handler i_bridge_data_parity_handler (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .side_in,
    .perr_in_l, .side_out, .irq);
  pci_far_end i_pci_far_end (.aclk, .aresetn, .report, .perr_in_l);

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    logic got;
    got = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= d;
    s_axi_wvalid <= 1; s_axi_bready <= 1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        got = 1;
        s_axi_bready <= 0;
        chk("bresp", 32'(s_axi_bresp), 32'(r));
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    logic got;
    got = 0;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        got = 1;
        s_axi_rready <= 0;
        chk("rdata", s_axi_rdata, d);
        chk("rresp", 32'(s_axi_rresp), 32'(r));
      end
    end
  endtask : axi_rd

  // Drives one core pulse; o1 holds the next cycle, o2 the one after.
  task automatic step(input int k, input side_in_s v, input logic rep);
    @(posedge aclk);
    side_in[k] <= v; report[k] <= rep;
    @(posedge aclk);
    side_in[k] <= '0; report <= '0;
    #1 o1 = side_out;
    @(posedge aclk);
    #1 o2 = side_out;
  endtask : step

  function automatic side_in_s dwp(logic [31:0] a, logic pe, logic m);
    dwp = '0;
    dwp.dw_phase = 1; dwp.dw.addr = a; dwp.dw.cmd = 4'h7;
    dwp.dw.data = a ^ 32'h5a5a0000; dwp.dw.be = 4'hf;
    dwp.dw.par_err = pe; dwp.dw.multi = m;
  endfunction : dwp

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_regs();
    for (int i = 0; i < 5; i++) axi_rd(8'(4*i), 32'h0, AXI_OKAY);
    axi_rd(8'h20, 32'h0, AXI_SLVERR);
    axi_wr(8'h20, 32'h1, AXI_SLVERR);
    $display("test regs done");
  endtask : t_regs

  task automatic t_cfg();
    side_in_s v;
    v = '0; v.cfg_wr = 1; v.cfg_pe = 1;
    step(0, v, 0);
    chk("cfg trdy", o1[0].trdy, 1);
    chk("cfg perr off", o2[0].perr_oe, 0);
    axi_rd(STAT_OFF, 32'h1, AXI_OKAY);
    chk("irq masked", irq, 0);
    axi_wr(MASK_OFF, 32'hf, AXI_OKAY);
    repeat (2) @(posedge aclk);
    #1 chk("irq on", irq, 1);
    axi_wr(CMD_OFF, 32'h1, AXI_OKAY);
    step(0, v, 0);
    chk("cfg store", o1[0].cfg_store, 1);
    chk("cfg perr", o2[0].perr_l, 0);
    axi_wr(STAT_OFF, 32'hf, AXI_OKAY);
    axi_rd(STAT_OFF, 32'h0, AXI_OKAY);
    repeat (2) @(posedge aclk);
    #1 chk("irq off", irq, 0);
    $display("test cfg done");
  endtask : t_cfg

  task automatic t_read();
    side_in_s e, g, r, f;
    e = '0; e.rd_vld = 1; e.rd_pe = 1;
    f = '0; f.rd_flush = 1;
    g = '0; g.rd_vld = 1;
    r = '0; r.rd_ret = 1;
    axi_wr(BCTL_OFF, 32'h1, AXI_OKAY);
    axi_wr(CMD_OFF, 32'h0, AXI_OKAY);
    step(1, e, 0);
    chk("s perr", o2[1].perr_l, 0);
    axi_rd(STAT_OFF, 32'hc, AXI_OKAY);
    step(0, r, 1);
    chk("fwd vld", o1[0].fwd_par_vld, 1);
    chk("fwd bad", o1[0].fwd_par, 1);
    repeat (4) @(posedge aclk);
    axi_rd(STAT_OFF, 32'hc, AXI_OKAY);
    step(0, e, 0);
    chk("p perr off", o2[0].perr_oe, 0);
    axi_rd(STAT_OFF, 32'hd, AXI_OKAY);
    step(1, r, 0);
    chk("up fwd bad", o1[1].fwd_par, 1);
    step(1, g, 0);
    step(0, r, 0);
    chk("fwd good", o1[0].fwd_par, 0);
    step(1, e, 0);
    step(0, f, 0);
    step(0, r, 0);
    chk("flushed", o1[0].fwd_par_vld, 0);
    axi_wr(STAT_OFF, 32'hf, AXI_OKAY);
    $display("test read done");
  endtask : t_read

  task automatic t_dw();
    side_in_s d, w;
    d = '0; d.dw_done = 1;
    w = dwp(32'h100, 0, 0);
    axi_wr(CMD_OFF, 32'h1, AXI_OKAY);
    axi_wr(BCTL_OFF, 32'h1, AXI_OKAY);
    step(0, dwp(32'h100, 1, 1), 0);
    chk("err stop", o1[0].stop, 1);
    chk("err perr", o2[0].perr_l, 0);
    chk("not queued", o2[0].q_valid, 0);
    step(0, w, 0);
    chk("retry", o1[0].retry, 1);
    chk("queued", 32'(o1[0].q === w.dw), 1);
    step(0, dwp(32'h104, 0, 0), 0);
    chk("mismatch retry", o1[0].retry, 1);
    @(posedge aclk);
    side_in[1].dw_dlv <= 1; report[1] <= 1;
    @(posedge aclk);
    report <= '0;
    repeat (5) @(posedge aclk);
    side_in[1].dw_dlv <= 0;
    step(1, d, 0);
    axi_rd(STAT_OFF, 32'h9, AXI_OKAY);
    axi_rd(QSTAT_OFF, 32'h5, AXI_OKAY);
    step(0, dwp(32'h100, 1, 0), 0);
    chk("rep trdy", o1[0].trdy, 1);
    chk("rep perr", o2[0].perr_l, 0);
    chk("rep kept", o2[0].q_valid, 1);
    step(0, dwp(32'h100, 0, 0), 0);
    chk("done trdy", o1[0].trdy, 1);
    chk("tgt perr", o2[0].perr_l, 0);
    chk("dequeued", o2[0].q_valid, 0);
    axi_wr(BCTL_OFF, 32'h0, AXI_OKAY);
    step(1, dwp(32'h200, 1, 1), 0);
    chk("off retry", o1[1].retry, 1);
    chk("off perr", o2[1].perr_oe, 0);
    axi_rd(STAT_OFF, 32'hd, AXI_OKAY);
    $display("test delayed write done");
  endtask : t_dw

  // ***************************************************************
  // Clock, reset, sequence and timeout
  // ***************************************************************
  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    aresetn = 0; s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0;
    s_axi_arvalid = 0; s_axi_rready = 0; s_axi_awaddr = '0;
    s_axi_araddr = '0; s_axi_wdata = '0; s_axi_wstrb = 4'hf;
    side_in = '0; report = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_cfg();
    t_read();
    t_dw();
    report_and_stop();
  end
endmodule : bridge_data_parity_handler_tb_top
